// >>> shared/exec_regs.svh
// constants for the clear, decrement and call execution unit
// Functional notes
// - watchdog kick clears counter and prescaler
// - watchdog kick sets expiry and sleep flags
// - call pushes program counter plus one
// - call loads immediate and latch bits 4:3
// - call takes two cycles, flags untouched
// - invert complements register, updates null flag only
// - destination bit selects accumulator or register
// - clear writes zero, sets null flag
// - decrement subtracts one, updates null flag only
// - zero accumulator loads zero, sets null flag
// - decrement skip on zero inserts no-operation
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
`define EXEC_DATA_W      8
`define EXEC_ADDR_W      7
`define EXEC_IMM_W       11
`define EXEC_PC_W        13
`define EXEC_LATCH_W     8
`define EXEC_LATCH_HI    4
`define EXEC_LATCH_LO    3
`define EXEC_STACK_DEPTH 8
`define EXEC_PTR_W       3
`define EXEC_ZERO_DATA   8'h00
`define EXEC_ONE_DATA    8'h01
`define EXEC_PC_STEP     13'h0001
`define EXEC_PC_RST      13'h0000
`define EXEC_ACC_RST     8'h00
`define EXEC_FLAG_RST    1'b1
`define EXEC_NULL_RST    1'b0
`endif

// >>> shared/exec_pkg.sv
// types for the clear, decrement and call execution unit
`include "exec_regs.svh"
package exec_pkg;
	typedef enum logic [2:0] {
		OP_OTHER       = 3'h0,
		OP_KICK        = 3'h1,
		OP_CALL        = 3'h2,
		OP_INVERT      = 3'h3,
		OP_CLEAR       = 3'h4,
		OP_DEC         = 3'h5,
		OP_ZERO_ACC    = 3'h6,
		OP_DEC_SKIP    = 3'h7
	} op_e;
	typedef enum logic [0:0] {
		ST_RUN    = 1'h0,
		ST_SECOND = 1'h1
	} state_e;
	typedef struct packed {
		op_e                      op;
		logic [`EXEC_ADDR_W-1:0]  addr;
		logic                     dest;
		logic [`EXEC_IMM_W-1:0]   imm;
	} instr_s;
	typedef struct packed {
		logic                     en;
		logic [`EXEC_ADDR_W-1:0]  addr;
		logic [`EXEC_DATA_W-1:0]  data;
	} file_wr_s;
	typedef struct packed {
		logic result_null;
		logic watchdog_expiry;
		logic sleep_entered;
	} flags_s;
endpackage : exec_pkg

// >>> hdl/return_stack.sv
// return address stack, head comes out of a register
`timescale 1ns/1ps
`include "exec_regs.svh"
module return_stack import exec_pkg::*; (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    push,
	input  wire logic [`EXEC_PC_W-1:0]   push_data,
	output logic      [`EXEC_PC_W-1:0]   stack_head
);
	typedef struct packed {
		logic [`EXEC_STACK_DEPTH-1:0][`EXEC_PC_W-1:0] mem;
		logic [`EXEC_PTR_W-1:0]                      ptr;
		logic [`EXEC_PC_W-1:0]                       head;
	} stk_s;
	stk_s stk_reg;
	stk_s stk_next;

	// circular: a push beyond depth overwrites the oldest entry
	always_comb begin
		stk_next = stk_reg;
		if (push) begin
			stk_next.mem[stk_reg.ptr] = push_data;
			stk_next.ptr              = stk_reg.ptr + 3'h1;
			stk_next.head             = push_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stk_reg <= '0;
		end else begin
			stk_reg <= stk_next;
		end
	end

	assign stack_head = stk_reg.head;
endmodule : return_stack

// >>> hdl/exec_unit.sv
// execution of watchdog kick, call, invert, clear and decrement instructions
`timescale 1ns/1ps
`include "exec_regs.svh"
module exec_unit import exec_pkg::*; (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      issue_valid,
	input  wire instr_s                    instr,
	input  wire logic [`EXEC_DATA_W-1:0]   file_rdata,
	input  wire logic [`EXEC_LATCH_W-1:0]  pc_high_latch,
	output logic                           issue_ready,
	output file_wr_s                       file_wr,
	output logic      [`EXEC_DATA_W-1:0]   acc,
	output flags_s                         flags,
	output logic                           wdt_clear,
	output logic                           prescaler_clear,
	output logic      [`EXEC_PC_W-1:0]     pc,
	output logic                           skip_nop,
	output logic      [`EXEC_PC_W-1:0]     stack_head
);
	typedef struct packed {
		state_e                   state;
		logic                     skip2;
		logic [`EXEC_PC_W-1:0]    pc;
		logic [`EXEC_DATA_W-1:0]  acc;
		flags_s                   flags;
		file_wr_s                 fw;
		logic                     wdt_clr;
		logic                     psc_clr;
		logic                     push;
		logic [`EXEC_PC_W-1:0]    push_data;
		logic                     ready;
		logic                     nop;
	} exec_s;

	exec_s exec_reg;
	exec_s exec_next;

	wire logic accept = issue_valid && exec_reg.ready;

	always_comb begin
		logic [`EXEC_DATA_W-1:0] res;
		res       = `EXEC_ZERO_DATA;
		exec_next = exec_reg;
		exec_next.fw.en   = 1'b0;
		exec_next.wdt_clr = 1'b0;
		exec_next.psc_clr = 1'b0;
		exec_next.push    = 1'b0;
		exec_next.nop     = 1'b0;
		case (exec_reg.state)
			ST_RUN: begin
				if (issue_valid) begin
					exec_next.pc = exec_reg.pc + `EXEC_PC_STEP;
					case (instr.op)
						OP_KICK: begin
							exec_next.wdt_clr               = 1'b1;
							exec_next.psc_clr               = 1'b1;
							exec_next.flags.watchdog_expiry = 1'b1;
							exec_next.flags.sleep_entered   = 1'b1;
						end
						OP_CALL: begin
							exec_next.push      = 1'b1;
							exec_next.push_data = exec_reg.pc + `EXEC_PC_STEP;
							exec_next.pc        = {pc_high_latch[`EXEC_LATCH_HI:`EXEC_LATCH_LO],
								instr.imm};
							exec_next.state     = ST_SECOND;
							exec_next.skip2     = 1'b0;
						end
						OP_INVERT, OP_DEC, OP_DEC_SKIP: begin
							if (instr.op == OP_INVERT) begin
								res = ~file_rdata;
							end else begin
								res = file_rdata - `EXEC_ONE_DATA;
							end
							if (instr.dest) begin
								exec_next.fw.en   = 1'b1;
								exec_next.fw.addr = instr.addr;
								exec_next.fw.data = res;
							end else begin
								exec_next.acc = res;
							end
							if (instr.op != OP_DEC_SKIP) begin
								exec_next.flags.result_null = (res == `EXEC_ZERO_DATA);
							end else if (res == `EXEC_ZERO_DATA) begin
								exec_next.state = ST_SECOND;
								exec_next.skip2 = 1'b1;
							end
						end
						OP_CLEAR: begin
							exec_next.fw.en             = 1'b1;
							exec_next.fw.addr           = instr.addr;
							exec_next.fw.data           = `EXEC_ZERO_DATA;
							exec_next.flags.result_null = 1'b1;
						end
						OP_ZERO_ACC: begin
							exec_next.acc               = `EXEC_ZERO_DATA;
							exec_next.flags.result_null = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
			ST_SECOND: begin
				exec_next.state = ST_RUN;
				if (exec_reg.skip2) begin
					exec_next.nop = 1'b1;
					exec_next.pc  = exec_reg.pc + `EXEC_PC_STEP;
				end
			end
			default: begin
				exec_next.state = ST_RUN;
			end
		endcase
		exec_next.ready = (exec_next.state == ST_RUN);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			exec_reg                       <= '0;
			exec_reg.state                 <= ST_RUN;
			exec_reg.pc                    <= `EXEC_PC_RST;
			exec_reg.acc                   <= `EXEC_ACC_RST;
			exec_reg.flags.result_null     <= `EXEC_NULL_RST;
			exec_reg.flags.watchdog_expiry <= `EXEC_FLAG_RST;
			exec_reg.flags.sleep_entered   <= `EXEC_FLAG_RST;
			exec_reg.ready                 <= 1'b1;
		end else begin
			exec_reg <= exec_next;
		end
	end

	return_stack return_stack_i (
		.clk        (clk),
		.rstn       (rstn),
		.push       (exec_reg.push),
		.push_data  (exec_reg.push_data),
		.stack_head (stack_head)
	);

	assign issue_ready     = exec_reg.ready;
	assign file_wr         = exec_reg.fw;
	assign acc             = exec_reg.acc;
	assign flags           = exec_reg.flags;
	assign wdt_clear       = exec_reg.wdt_clr;
	assign prescaler_clear = exec_reg.psc_clr;
	assign pc              = exec_reg.pc;
	assign skip_nop        = exec_reg.nop;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_kick_clear;
		accept && instr.op == OP_KICK |=> wdt_clear && prescaler_clear
			##1 (wdt_clear == $past(accept && instr.op == OP_KICK));
	endproperty
	a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear watchdog");

	property p_kick_flags;
		accept && instr.op == OP_KICK |=> flags.watchdog_expiry && flags.sleep_entered
			&& flags.result_null == $past(flags.result_null);
	endproperty
	a_kick_flags: assert property (p_kick_flags) else $error("kick flags wrong");

	property p_call_push;
		accept && instr.op == OP_CALL |=> ##1 stack_head == $past(pc, 2) + `EXEC_PC_STEP;
	endproperty
	a_call_push: assert property (p_call_push) else $error("call pushed wrong address");

	property p_call_target;
		accept && instr.op == OP_CALL |=>
			pc == {$past(pc_high_latch[`EXEC_LATCH_HI:`EXEC_LATCH_LO]), $past(instr.imm)};
	endproperty
	a_call_target: assert property (p_call_target) else $error("call target wrong");

	property p_call_two_cycles;
		accept && instr.op == OP_CALL |=> !issue_ready && $stable(flags) ##1 issue_ready
			&& $stable(flags) && $stable(pc);
	endproperty
	a_call_two_cycles: assert property (p_call_two_cycles) else $error("call timing wrong");

	property p_invert;
		accept && instr.op == OP_INVERT |=> (file_wr.en ? file_wr.data : acc) == ~$past(file_rdata)
			&& flags.result_null == ($past(file_rdata) == 8'hFF) && $stable(flags.sleep_entered);
	endproperty
	a_invert: assert property (p_invert) else $error("invert result wrong");

	property p_route;
		accept && (instr.op == OP_DEC || instr.op == OP_INVERT || instr.op == OP_DEC_SKIP)
			|=> file_wr.en == $past(instr.dest)
			&& (file_wr.en || $stable({file_wr.addr, file_wr.data}))
			&& (!file_wr.en || $stable(acc));
	endproperty
	a_route: assert property (p_route) else $error("destination routing wrong");

	property p_clear;
		accept && instr.op == OP_CLEAR |=> file_wr.en && file_wr.data == 8'h00
			&& file_wr.addr == $past(instr.addr) && flags.result_null;
	endproperty
	a_clear: assert property (p_clear) else $error("clear wrong");

	property p_dec;
		accept && instr.op == OP_DEC |=> (file_wr.en ? file_wr.data : acc)
			== $past(file_rdata) - 8'h01 && flags.result_null == ($past(file_rdata) == 8'h01);
	endproperty
	a_dec: assert property (p_dec) else $error("decrement wrong");

	property p_zero_acc;
		accept && instr.op == OP_ZERO_ACC |=> acc == 8'h00 && flags.result_null && !file_wr.en;
	endproperty
	a_zero_acc: assert property (p_zero_acc) else $error("zero accumulator wrong");

	property p_skip;
		accept && instr.op == OP_DEC_SKIP && file_rdata == 8'h01 |=> !issue_ready && $stable(flags)
			##1 skip_nop && issue_ready && pc == $past(pc) + `EXEC_PC_STEP;
	endproperty
	a_skip: assert property (p_skip) else $error("skip not taken");

	property p_no_skip;
		accept && instr.op == OP_DEC_SKIP && file_rdata != 8'h01 |=> issue_ready
			&& $stable(flags) ##1 !skip_nop;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("nonzero skip stalled");

	c_kick: cover property (accept && instr.op == OP_KICK);
	c_call: cover property (accept && instr.op == OP_CALL ##2 accept);
	c_skip: cover property (accept && instr.op == OP_DEC_SKIP ##2 skip_nop);
	c_inv_file: cover property (accept && instr.op == OP_INVERT && instr.dest);
endmodule : exec_unit

// >>> tb/exec_partner.sv
// register file model facing the execution unit
`timescale 1ns/1ps
module exec_partner import exec_pkg::*; (
	input  wire logic     clk,
	input  wire instr_s   instr,
	input  wire file_wr_s file_wr,
	output logic [7:0]    file_rdata
);
	logic [7:0] mem [128];
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i);
		end
	end
	assign file_rdata = mem[instr.addr];
	always @(posedge clk) begin
		if (file_wr.en === 1'b1) begin
			mem[file_wr.addr] <= file_wr.data;
		end
	end
endmodule : exec_partner

// >>> tb/cpu_clear_dec_call_exec_bench.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
module cpu_clear_dec_call_exec_bench import exec_pkg::*;;
	logic        clk, rstn, issue_valid, issue_ready, wdt_clear, prescaler_clear, skip_nop;
	instr_s      instr;
	file_wr_s    file_wr;
	flags_s      flags, fb;
	logic [7:0]  file_rdata, pc_high_latch, acc;
	logic [12:0] pc, stack_head, ep, ret;
	int          miscompares, n_compared, cycles;

	exec_unit exec_unit_i (.clk(clk), .rstn(rstn), .issue_valid(issue_valid), .instr(instr),
		.file_rdata(file_rdata), .pc_high_latch(pc_high_latch), .issue_ready(issue_ready),
		.file_wr(file_wr), .acc(acc), .flags(flags), .wdt_clear(wdt_clear),
		.prescaler_clear(prescaler_clear), .pc(pc), .skip_nop(skip_nop),
		.stack_head(stack_head));
	exec_partner exec_partner_i (.clk(clk), .instr(instr), .file_wr(file_wr),
		.file_rdata(file_rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task end_sim;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			end_sim();
		end
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// issue one instruction, return in the cycle after it is taken
	task go(input op_e op, input logic [6:0] a, input logic d, input logic [10:0] k);
		@(posedge clk);
		issue_valid <= 1'b1;
		instr <= '{op: op, addr: a, dest: d, imm: k};
		@(posedge clk);
		issue_valid <= 1'b0;
		#1;
		ep = (op == OP_CALL) ? {pc_high_latch[4:3], k} : ep + 13'h0001;
		chk(pc, ep);
	endtask : go

	task t_kick;
		fb = flags;
		go(OP_KICK, 7'h00, 1'b0, 11'h000);
		chk(wdt_clear, 1'b1);
		chk(prescaler_clear, 1'b1);
		chk(flags, {fb.result_null, 2'b11});
		@(posedge clk);
		#1;
		chk(wdt_clear, 1'b0);
		$display("kick test done");
	endtask : t_kick

	task t_call;
		@(posedge clk);
		pc_high_latch <= 8'h18;
		ret = ep + 13'h0001;
		fb = flags;
		go(OP_CALL, 7'h00, 1'b0, 11'h7FF);
		chk(pc, 13'h1FFF);
		chk(issue_ready, 1'b0);
		chk(flags, fb);
		@(posedge clk);
		#1;
		chk(stack_head, ret);
		chk(issue_ready, 1'b1);
		$display("call test done");
	endtask : t_call

	task t_alu(input op_e op, input logic [6:0] a, input logic d, input logic [7:0] r);
		go(op, a, d, 11'h000);
		chk(file_wr.en, d);
		if (d) begin
			chk(file_wr.addr, a);
			chk(file_wr.data, r);
		end else begin
			chk(acc, r);
		end
		chk(flags, {r == 8'h00, 2'b11});
		$display("alu test done");
	endtask : t_alu

	task t_clear_zero;
		go(OP_CLEAR, 7'h20, 1'b0, 11'h000);
		chk(file_wr, {1'b1, 7'h20, 8'h00});
		chk(flags.result_null, 1'b1);
		t_alu(OP_INVERT, 7'h00, 1'b0, 8'hFF);
		go(OP_ZERO_ACC, 7'h00, 1'b0, 11'h000);
		chk(acc, 8'h00);
		chk(flags.result_null, 1'b1);
		fb = flags;
		go(OP_OTHER, 7'h11, 1'b1, 11'h000);
		chk(file_wr.en, 1'b0);
		chk(flags, fb);
		$display("clear test done");
	endtask : t_clear_zero

	task t_skip(input logic d, input logic [7:0] r);
		fb = flags;
		go(OP_DEC_SKIP, 7'h02, d, 11'h000);
		chk(flags, fb);
		chk(d ? file_wr.data : acc, r);
		chk(issue_ready, r != 8'h00);
		@(posedge clk);
		#1;
		chk(skip_nop, r == 8'h00);
		if (r == 8'h00) begin
			ep = ep + 13'h0001;
		end
		chk(pc, ep);
		chk(issue_ready, 1'b1);
		$display("skip test done");
	endtask : t_skip

	initial begin
		rstn = 1'b0;
		issue_valid = 1'b0;
		instr = '0;
		pc_high_latch = 8'h00;
		ep = 13'h0000;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk({issue_ready, flags, acc}, {1'b1, 3'b011, 8'h00});
		chk(pc, 13'h0000);
		t_kick();
		t_alu(OP_INVERT, 7'h55, 1'b1, 8'hAA);
		t_alu(OP_DEC, 7'h55, 1'b0, 8'hA9);
		t_alu(OP_INVERT, 7'h7F, 1'b0, 8'h80);
		t_alu(OP_DEC, 7'h01, 1'b1, 8'h00);
		t_clear_zero();
		t_call();
		t_skip(1'b1, 8'h01);
		t_skip(1'b0, 8'h00);
		end_sim();
	end
endmodule : cpu_clear_dec_call_exec_bench
